// File: hdl/ism_consts.svh
// Purpose: constants shared by the device and the bench of the i2c word service pair
// Assumes: 40 MHz system clock, byte addresses on the avalon side
// Notes: registers sit in the low byte of each word
// Behaviour
// - master rx: dummy write resumes, ack driven low
// - data read after address is not valid data
// - word end raises irq, clears pending flag
// - ack mode off, count 000: no ack clock
// - count 001, ack off: one high bit, nack
// - after final bit software issues stop
// - slave address or general call match raises irq
// - addressed slave raises irq every word
// - lost arbitration falls back to slave, irq
// - lost arbitration word end clears pending flag
// - irq holds scl low until pending set
// - slave tx: check last bit, release or continue
// - read address sets transmit and addressed flags
// - dummy write clears lost flag, sets pending
// - write address or general call: resume by write
// - slave rx: set count, read, dummy write
// - own address 0x00 matches start byte 0x01
// - sda sampled on scl rise into last bit
// - bit count 000 means eight bits
`ifndef ISM_CONSTS_SVH
`define ISM_CONSTS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ISM_OFS_CTRL_ONE 5'h00
`define ISM_OFS_CTRL_TWO 5'h04
`define ISM_OFS_STATUS 5'h08
`define ISM_OFS_DATA 5'h0c
`define ISM_OFS_OWN_ADDR 5'h10

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define ISM_C1_ACK 3
`define ISM_C1_NADET 4
`define ISM_C2_PIN 0
`define ISM_C2_BB 1
`define ISM_C2_TRX 2
`define ISM_C2_MST 3
`define ISM_OA_FREE 0
`define ISM_RST_BC 3'h0
`define ISM_RST_OWN 7'h00
`define ISM_WORD_BITS 4'h8
`define ISM_GEN_CALL 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define ISM_CLK_NS 25
`define ISM_T_LOW_NS 4700
`define ISM_T_HIGH_NS 4000
`define ISM_T_LOW_CYC ((`ISM_T_LOW_NS + `ISM_CLK_NS - 1) / `ISM_CLK_NS)
`define ISM_T_HIGH_CYC ((`ISM_T_HIGH_NS + `ISM_CLK_NS - 1) / `ISM_CLK_NS)

`endif

// File: hdl/ism_dev.sv
// Purpose: serial bus controller word engine, master and slave
// Assumes: avalon-mm slave with one wait cycle per access
// Notes: restart is not handled; stop ends master mode
`default_nettype none
`include "ism_consts.svh"

module ism_dev (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // avalon-mm slave
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // event
    output logic o_serial_bus_irq,
    // serial bus
    ism_if.dev bus
);

    ism_pkg::ism_dev_s r;
    ism_pkg::ism_dev_s n;
    logic scl_rise, scl_fall, start_ev, stop_ev;
    logic wr_now, rd_now, upd, tx_now, rx_ack, match, gcall, scl_low, sda_low;
    logic [3:0] nd;
    logic [7:0] wd;
    function automatic logic [3:0] ism_bits(input logic first, input logic [2:0] bc);
        ism_bits = (first || bc == 3'h0) ? `ISM_WORD_BITS : {1'b0, bc};
    endfunction
    always_comb begin
        n = r;
        n.irq = 1'b0;
        upd = 1'b0;
        wd = i_avs_writedata[7:0];
        // ----------------------------------------
        // synchronisers and bus conditions
        // ----------------------------------------
        n.scl_s1 = bus.scl;
        n.scl_s2 = r.scl_s1;
        n.scl_q = r.scl_s2;
        n.sda_s1 = bus.sda;
        n.sda_s2 = r.sda_s1;
        n.sda_q = r.sda_s2;
        scl_rise = r.scl_s2 & ~r.scl_q;
        scl_fall = ~r.scl_s2 & r.scl_q;
        start_ev = r.scl_s2 & r.scl_q & r.sda_q & ~r.sda_s2;
        stop_ev = r.scl_s2 & r.scl_q & ~r.sda_q & r.sda_s2;
        nd = ism_bits(r.first, r.bc);
        match = ~r.nadet & ~r.free_fmt & (r.sh[7:1] == r.own);
        gcall = ~r.nadet & ~r.free_fmt & (r.sh == `ISM_GEN_CALL);
        // ----------------------------------------
        // master clocking and slave hold timer
        // ----------------------------------------
        unique case (r.ms)
            ism_pkg::MS_IDLE: begin
                if (r.hold && r.pin) begin
                    // scl still low for a full low period after release
                    if (r.cnt == 8'(`ISM_T_LOW_CYC - 1)) begin
                        n.hold = 1'b0;
                        n.cnt = 8'h00;
                    end else begin
                        n.cnt = r.cnt + 8'h01;
                    end
                end else begin
                    n.cnt = 8'h00;
                end
            end
            ism_pkg::MS_START, ism_pkg::MS_HIGH, ism_pkg::MS_STOP_HIGH: begin
                n.cnt = r.cnt + 8'h01;
                if (r.cnt == 8'(`ISM_T_HIGH_CYC - 1)) begin
                    n.cnt = 8'h00;
                    n.ms = (r.ms == ism_pkg::MS_STOP_HIGH) ? ism_pkg::MS_IDLE : ism_pkg::MS_LOW;
                end
            end
            ism_pkg::MS_LOW, ism_pkg::MS_STOP_LOW: begin
                if (!r.pin) begin
                    n.cnt = 8'h00;
                end else if (r.cnt == 8'(`ISM_T_LOW_CYC - 1)) begin
                    n.cnt = 8'h00;
                    n.ms = (r.ms == ism_pkg::MS_LOW) ? ism_pkg::MS_RISE : ism_pkg::MS_STOP_RISE;
                end else begin
                    n.cnt = r.cnt + 8'h01;
                end
            end
            ism_pkg::MS_RISE, ism_pkg::MS_STOP_RISE: begin
                // waits out any slave stretching the clock
                if (r.scl_s2) begin
                    n.ms = (r.ms == ism_pkg::MS_RISE) ? ism_pkg::MS_HIGH : ism_pkg::MS_STOP_HIGH;
                end
            end
        endcase
        // ----------------------------------------
        // register access, software clears first
        // ----------------------------------------
        wr_now = i_avs_write & ~r.waitreq & i_avs_byteenable[0];
        rd_now = i_avs_read & ~r.waitreq;
        n.waitreq = ~((i_avs_read | i_avs_write) & r.waitreq);
        if (i_avs_read && r.waitreq) begin
            case (i_avs_address)
                `ISM_OFS_CTRL_ONE: n.rdata = {3'h0, r.nadet, r.ack_mode, r.bc};
                `ISM_OFS_CTRL_TWO: n.rdata = {4'h0, r.master_select, r.trx, r.bb, r.pin};
                `ISM_OFS_STATUS: n.rdata = {r.master_select, r.trx, r.bb, r.pin, r.al, r.addressed_as_slave_flag, r.ad0, r.lrb};
                `ISM_OFS_DATA: n.rdata = r.sh;
                `ISM_OFS_OWN_ADDR: n.rdata = {r.own, r.free_fmt};
                default: n.rdata = 8'h00;
            endcase
        end
        if (rd_now && i_avs_address == `ISM_OFS_DATA) begin
            n.al = 1'b0;
            n.addressed_as_slave_flag = 1'b0;
        end
        if (wr_now) begin
            case (i_avs_address)
                `ISM_OFS_CTRL_ONE: begin
                    n.bc = wd[2:0];
                    n.ack_mode = wd[`ISM_C1_ACK];
                    n.nadet = wd[`ISM_C1_NADET];
                end
                `ISM_OFS_CTRL_TWO: begin
                    n.al = 1'b0;
                    if (wd[`ISM_C2_MST] && wd[`ISM_C2_BB] && wd[`ISM_C2_PIN] && !r.bb) begin
                        n.master_select = 1'b1;
                        n.trx = 1'b1;
                        n.pin = 1'b1;
                        n.ms = ism_pkg::MS_START;
                        n.cnt = 8'h00;
                    end else if (wd[`ISM_C2_MST] && !wd[`ISM_C2_BB] && wd[`ISM_C2_PIN] && r.master_select && r.bb) begin
                        n.pin = 1'b1;
                        n.ms = ism_pkg::MS_STOP_LOW;
                        n.cnt = 8'h00;
                    end else begin
                        n.master_select = wd[`ISM_C2_MST];
                        n.trx = wd[`ISM_C2_TRX];
                        if (wd[`ISM_C2_PIN]) begin
                            n.pin = 1'b1;
                        end
                    end
                end
                `ISM_OFS_DATA: begin
                    n.sh = wd;
                    n.pin = 1'b1;
                    n.al = 1'b0;
                    n.addressed_as_slave_flag = 1'b0;
                    upd = 1'b1;
                end
                `ISM_OFS_OWN_ADDR: begin
                    n.own = wd[7:1];
                    n.free_fmt = wd[`ISM_OA_FREE];
                end
                default: begin
                end
            endcase
        end
        // ----------------------------------------
        // bit engine, hardware sets win
        // ----------------------------------------
        if (start_ev) begin
            n.bb = 1'b1;
            n.armed = 1'b0;
            n.bitcnt = 4'h0;
            n.first = 1'b1;
            n.ad0 = 1'b0;
            n.sel = 1'b0;
            n.eng_low = 1'b0;
        end else if (stop_ev) begin
            n.bb = 1'b0;
            n.master_select = 1'b0;
            n.trx = 1'b0;
            n.sel = 1'b0;
            n.ad0 = 1'b0;
            n.addressed_as_slave_flag = 1'b0;
            n.armed = 1'b0;
            n.first = 1'b0;
            n.lost = 1'b0;
            n.hold = 1'b0;
            n.eng_low = 1'b0;
        end
        if (scl_rise) begin
            n.lrb = r.sda_s2;
            if (r.armed && r.bitcnt < nd) begin
                n.sh = {r.sh[6:0], r.sda_s2};
                if (r.master_select && r.trx && r.sh[7] && !r.sda_s2) begin
                    n.al = 1'b1;
                    n.master_select = 1'b0;
                    n.lost = 1'b1;
                end
            end
        end
        if (scl_fall && r.bb) begin
            upd = 1'b1;
            if (!r.armed) begin
                n.armed = 1'b1;
            end else if (r.bitcnt + 4'h1 == nd + {3'h0, r.first | r.ack_mode}) begin
                n.bitcnt = 4'h0;
                n.first = 1'b0;
                if (r.first && r.master_select && !r.lrb && r.sh[0]) begin
                    n.trx = 1'b0;
                end
                if (r.first && !r.master_select && r.free_fmt) begin
                    n.sel = 1'b1;
                    n.addressed_as_slave_flag = 1'b1;
                end
                if (r.master_select || r.sel || r.lost || (r.first && r.free_fmt)) begin
                    n.irq = 1'b1;
                    n.pin = 1'b0;
                    n.hold = ~n.master_select;
                    n.lost = 1'b0;
                end
            end else begin
                n.bitcnt = r.bitcnt + 4'h1;
                if (r.first && !r.master_select && r.bitcnt + 4'h1 == nd && (match || gcall)) begin
                    n.sel = 1'b1;
                    n.addressed_as_slave_flag = 1'b1;
                    n.ad0 = gcall;
                    n.trx = match & r.sh[0];
                end
            end
        end
        tx_now = n.master_select ? n.trx : (n.sel & n.trx);
        // receivers never put the buffer on the line
        rx_ack = (n.ack_mode & ~n.trx & (n.master_select | n.sel)) | (n.first & n.sel & ~n.master_select);
        if (upd) begin
            n.eng_low = n.armed & ((n.bitcnt < ism_bits(n.first, n.bc)) ? (tx_now & ~n.sh[7]) : rx_ack);
        end
        if (!n.master_select && n.ms != ism_pkg::MS_IDLE) begin
            n.ms = ism_pkg::MS_IDLE;
        end
        // ----------------------------------------
        // pin drive
        // ----------------------------------------
        scl_low = n.hold | n.ms == ism_pkg::MS_LOW | n.ms == ism_pkg::MS_STOP_LOW;
        sda_low = n.ms == ism_pkg::MS_START | (n.ms == ism_pkg::MS_LOW & ~n.armed) |
                  n.ms == ism_pkg::MS_STOP_LOW | n.ms == ism_pkg::MS_STOP_RISE |
                  n.ms == ism_pkg::MS_STOP_HIGH | n.eng_low;
        n.scl_oe_n = ~scl_low;
        n.sda_oe_n = ~sda_low;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r <= '0;
            r.scl_s1 <= 1'b1;
            r.scl_s2 <= 1'b1;
            r.scl_q <= 1'b1;
            r.sda_s1 <= 1'b1;
            r.sda_s2 <= 1'b1;
            r.sda_q <= 1'b1;
            r.waitreq <= 1'b1;
            r.bc <= `ISM_RST_BC;
            r.own <= `ISM_RST_OWN;
            r.pin <= 1'b1;
            r.ms <= ism_pkg::MS_IDLE;
            r.scl_oe_n <= 1'b1;
            r.sda_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign o_avs_readdata = {24'h000000, r.rdata};
    assign o_avs_waitrequest = r.waitreq;
    assign o_serial_bus_irq = r.irq;
    assign bus.dev_scl_o = 1'b0;
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_scl_oe_n = r.scl_oe_n;
    assign bus.dev_sda_oe_n = r.sda_oe_n;

endmodule // ism_dev

`default_nettype wire

// File: hdl/ism_far.sv
// Purpose: external slave on the serial bus, far end of the link
// Assumes: never stretches scl; 7-bit addressing only
// Notes: a master nack on a read ends the transfer
`default_nettype none

module ism_far (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // user side
    input wire logic [6:0] i_own_addr,
    input wire logic i_ack_enable,
    input wire logic [7:0] i_tx_byte,
    output logic [7:0] o_rx_byte,
    output logic o_rx_valid,
    output logic o_tx_taken,
    output logic o_nack_seen,
    // serial bus
    ism_if.far bus
);

    ism_pkg::ism_far_s r;
    ism_pkg::ism_far_s n;
    logic scl_rise, scl_fall, start_ev, stop_ev;

    always_comb begin
        n = r;
        n.rx_valid = 1'b0;
        n.tx_taken = 1'b0;
        n.nack_seen = 1'b0;
        n.scl_s1 = bus.scl;
        n.scl_s2 = r.scl_s1;
        n.scl_q = r.scl_s2;
        n.sda_s1 = bus.sda;
        n.sda_s2 = r.sda_s1;
        n.sda_q = r.sda_s2;
        scl_rise = r.scl_s2 & ~r.scl_q;
        scl_fall = ~r.scl_s2 & r.scl_q;
        start_ev = r.scl_s2 & r.scl_q & r.sda_q & ~r.sda_s2;
        stop_ev = r.scl_s2 & r.scl_q & ~r.sda_q & r.sda_s2;
        if (start_ev) begin
            n.st = ism_pkg::FS_ADDR;
            n.armed = 1'b0;
            n.bitcnt = 4'h0;
            n.sda_oe_n = 1'b1;
        end else if (stop_ev) begin
            n.st = ism_pkg::FS_IDLE;
            n.sda_oe_n = 1'b1;
        end else if (r.st != ism_pkg::FS_IDLE) begin
            if (scl_rise) begin
                if (r.bitcnt < 4'h8) begin
                    n.sh = {r.sh[6:0], r.sda_s2};
                end else if (r.st == ism_pkg::FS_READ && r.sda_s2) begin
                    n.nack_seen = 1'b1;
                    n.st = ism_pkg::FS_IDLE;
                end
            end
            if (scl_fall) begin
                if (!r.armed) begin
                    n.armed = 1'b1;
                end else if (r.bitcnt == 4'h7) begin
                    n.bitcnt = 4'h8;
                    n.sda_oe_n = 1'b1;
                    if (r.st == ism_pkg::FS_ADDR) begin
                        if (r.sh[7:1] == i_own_addr && i_ack_enable) begin
                            n.sda_oe_n = 1'b0;
                        end else begin
                            n.st = ism_pkg::FS_IDLE;
                        end
                    end else if (r.st == ism_pkg::FS_WRITE) begin
                        n.rx_byte = r.sh;
                        n.rx_valid = 1'b1;
                        n.sda_oe_n = ~i_ack_enable;
                    end
                end else if (r.bitcnt == 4'h8) begin
                    n.bitcnt = 4'h0;
                    n.sda_oe_n = 1'b1;
                    if (r.st == ism_pkg::FS_ADDR) begin
                        n.st = r.sh[0] ? ism_pkg::FS_READ : ism_pkg::FS_WRITE;
                    end
                    if ((r.st == ism_pkg::FS_ADDR && r.sh[0]) || r.st == ism_pkg::FS_READ) begin
                        n.sh = i_tx_byte;
                        n.tx_taken = 1'b1;
                        n.sda_oe_n = i_tx_byte[7];
                    end
                end else begin
                    n.bitcnt = r.bitcnt + 4'h1;
                    // the shifter samples our own bits back, so its top is always the next bit
                    n.sda_oe_n = (r.st == ism_pkg::FS_READ) ? r.sh[7] : 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            r <= '0;
            r.scl_s1 <= 1'b1;
            r.scl_s2 <= 1'b1;
            r.scl_q <= 1'b1;
            r.sda_s1 <= 1'b1;
            r.sda_s2 <= 1'b1;
            r.sda_q <= 1'b1;
            r.st <= ism_pkg::FS_IDLE;
            r.sda_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign o_rx_byte = r.rx_byte;
    assign o_rx_valid = r.rx_valid;
    assign o_tx_taken = r.tx_taken;
    assign o_nack_seen = r.nack_seen;
    assign bus.far_sda_o = 1'b0;
    assign bus.far_sda_oe_n = r.sda_oe_n;

endmodule // ism_far

`default_nettype wire

// File: hdl/ism_if.sv
// Purpose: open-drain serial bus joining device and far end
// Assumes: pull-ups, a low enable pulls the line low
// Notes: wired-and resolved here, not in the ends
`default_nettype none

interface ism_if;
    logic dev_scl_o;
    logic dev_scl_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic far_sda_o;
    logic far_sda_oe_n;
    logic scl;
    logic sda;

    assign scl = dev_scl_oe_n | dev_scl_o;
    assign sda = (dev_sda_oe_n | dev_sda_o) & (far_sda_oe_n | far_sda_o);

    modport dev (output dev_scl_o, dev_scl_oe_n, dev_sda_o, dev_sda_oe_n, input scl, sda);
    modport far (output far_sda_o, far_sda_oe_n, input scl, sda);
endinterface

`default_nettype wire

// File: hdl/ism_pkg.sv
// Purpose: state types of both ends
// Assumes: nothing beyond the constants header
// Notes: one packed struct per module
`default_nettype none

package ism_pkg;

    // ----------------------------------------
    // device master clocking
    // ----------------------------------------
    typedef enum logic [2:0] {
        MS_IDLE = 3'h0,
        MS_START = 3'h1,
        MS_LOW = 3'h2,
        MS_RISE = 3'h3,
        MS_HIGH = 3'h4,
        MS_STOP_LOW = 3'h5,
        MS_STOP_RISE = 3'h6,
        MS_STOP_HIGH = 3'h7
    } ism_mst_e;

    typedef struct packed {
        logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
        logic waitreq;
        logic [7:0] rdata;
        logic [2:0] bc;
        logic ack_mode, nadet, free_fmt;
        logic [6:0] own;
        logic master_select, trx, bb, pin, al, addressed_as_slave_flag, ad0, lrb;
        logic [7:0] sh;
        logic [3:0] bitcnt;
        logic armed, first, sel, lost, hold, eng_low;
        ism_mst_e ms;
        logic [7:0] cnt;
        logic scl_oe_n, sda_oe_n, irq;
    } ism_dev_s;

    // ----------------------------------------
    // far end slave
    // ----------------------------------------
    typedef enum logic [1:0] {
        FS_IDLE = 2'h0,
        FS_ADDR = 2'h1,
        FS_WRITE = 2'h2,
        FS_READ = 2'h3
    } ism_far_e;

    typedef struct packed {
        logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
        ism_far_e st;
        logic armed;
        logic [3:0] bitcnt;
        logic [7:0] sh;
        logic sda_oe_n;
        logic [7:0] rx_byte;
        logic rx_valid, tx_taken, nack_seen;
    } ism_far_s;

endpackage

`default_nettype wire

// File: verification/ism_props.sv
// Purpose: bus checks on the joined device and far end
// Assumes: only the device drives scl
// Notes: low and high counters saturate, so long idle gaps are harmless
`default_nettype none

module ism_props (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // watched signals
    input wire logic i_irq,
    input wire logic i_scl_oe_n,
    input wire logic i_sda_oe_n,
    input wire logic i_far_oe_n,
    input wire logic i_scl,
    input wire logic i_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] low_cnt;
    logic [11:0] high_cnt;
    logic [3:0] rises;
    logic scl_q;
    logic sda_q;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);
    // --------------------
    // helper counters
    // --------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            low_cnt <= 12'h000;
            high_cnt <= 12'h000;
            rises <= 4'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            low_cnt <= i_scl_oe_n ? 12'h000 : low_cnt + {11'h000, low_cnt != 12'hfff};
            high_cnt <= !i_scl_oe_n ? 12'h000 : high_cnt + {11'h000, high_cnt != 12'hfff};
            // start or word end restarts the clock count
            rises <= ((i_scl && sda_q && !i_sda) || i_irq) ? 4'h0 : rises + {3'h0, i_scl && !scl_q};
            scl_q <= i_scl;
            sda_q <= i_sda;
        end
    end
    // --------------------
    // properties
    // --------------------
    a_scl_low_time: assert property ($rose(i_scl_oe_n) |-> low_cnt >= 12'h0bc)
        else $error("scl released too early");
    a_scl_high_time: assert property ($fell(i_scl_oe_n) |-> high_cnt >= 12'h0a0)
        else $error("scl high period too short");
    a_irq_holds_scl: assert property (i_irq |-> (!i_scl) [*8])
        else $error("scl not held low after irq");
    a_irq_after_fall: assert property (i_irq |-> low_cnt < 12'h010)
        else $error("irq not tied to a clock fall");
    a_irq_single: assert property (i_irq |=> !i_irq)
        else $error("irq longer than one cycle");
    a_word_clocks: assert property (i_irq |-> rises inside {4'h1, 4'h8, 4'h9})
        else $error("wrong clock count in word");
    a_rx_no_drive: assert property (!i_far_oe_n && i_scl |-> i_sda_oe_n)
        else $error("device drives sda against far end");
    a_far_stable: assert property (i_scl && scl_q |-> $stable(i_far_oe_n))
        else $error("far end changed sda with scl high");
    c_word_end: cover property (i_irq);
    c_far_drives: cover property (i_scl && !i_far_oe_n);
    c_nack_bit: cover property (i_irq && rises == 4'h1);
endmodule // ism_props

`default_nettype wire

// File: verification/tb_i2c_master_rx_slave_service.sv
// Purpose: self-checking bench for device and far end
// Assumes: far end acks its own address, never stretches scl
// Notes: slave-mode service needs a second master, not driven here
`default_nettype none
`include "ism_consts.svh"

module tb_i2c_master_rx_slave_service;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk_sys = 1'b0;
    logic i_rst_b = 1'b0;
    logic [4:0] addr = 5'h00;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hf;
    logic [7:0] tx_byte = 8'h96;
    logic [31:0] rdata;
    logic waitreq;
    logic irq;
    logic [7:0] rx_byte;
    logic nack;
    logic nack_seen = 1'b0;
    logic rx_valid;
    logic tx_taken;
    logic rx_seen = 1'b0;
    int taken = 0;
    logic [31:0] v;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    ism_if u_ism_if ();
    ism_dev u_ism_dev (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_avs_address(addr),
        .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .o_serial_bus_irq(irq), .bus(u_ism_if));
    ism_far u_ism_far (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_own_addr(7'h2a), .i_ack_enable(1'b1),
        .i_tx_byte(tx_byte), .o_rx_byte(rx_byte), .o_rx_valid(rx_valid), .o_tx_taken(tx_taken), .o_nack_seen(nack),
        .bus(u_ism_if));
    ism_props u_ism_props (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_irq(irq),
        .i_scl_oe_n(u_ism_if.dev_scl_oe_n), .i_sda_oe_n(u_ism_if.dev_sda_oe_n),
        .i_far_oe_n(u_ism_if.far_sda_oe_n), .i_scl(u_ism_if.scl), .i_sda(u_ism_if.sda));

    always #12.5 i_clk_sys = ~i_clk_sys;

    // --------------------
    // tasks
    // --------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // pulse seen anywhere in the run is kept
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (nack === 1'b1) nack_seen <= 1'b1;
        if (rx_valid === 1'b1) rx_seen <= 1'b1;
        if (tx_taken === 1'b1) taken <= taken + 1;
        if (cycles == 32'h0000ea60) begin
            mismatches = mismatches + 1;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        addr <= a;
        wdata <= {24'h000000, d};
        wr_en <= 1'b1;
        // waitrequest is taken as it stood at the edge
        do @(posedge i_clk_sys); while (waitreq !== 1'b0);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        do @(posedge i_clk_sys); while (waitreq !== 1'b0);
        d = rdata;
        rd_en <= 1'b0;
    endtask

    task automatic wait_irq;
        do @(negedge i_clk_sys); while (irq !== 1'b1);
    endtask

    task automatic stop_bus;
        wr(`ISM_OFS_CTRL_TWO, 8'h0d);
        do rd(`ISM_OFS_STATUS, v); while (v[5] !== 1'b0);
        rd(`ISM_OFS_CTRL_TWO, v);
        chk("ctrl_two after stop", v, 32'h00000001);
    endtask

    // --------------------
    // main sequence
    // --------------------
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_rst_b <= 1'b1;
        rd(`ISM_OFS_STATUS, v);
        chk("status reset", v, 32'h00000010);
        rd(5'h14, v);
        chk("unmapped read", v, 32'h00000000);
        wr(`ISM_OFS_CTRL_ONE, 8'h08);
        be <= 4'he;
        wr(`ISM_OFS_CTRL_ONE, 8'h17);
        be <= 4'hf;
        rd(`ISM_OFS_CTRL_ONE, v);
        chk("ctrl_one lane off", v, 32'h00000008);
        wr(`ISM_OFS_OWN_ADDR, 8'ha0);
        $display("test registers done");
        wr(`ISM_OFS_DATA, 8'h54);
        wr(`ISM_OFS_CTRL_TWO, 8'h0f);
        wait_irq();
        rd(`ISM_OFS_STATUS, v);
        chk("status write address", v, 32'h000000e0);
        wr(`ISM_OFS_DATA, 8'hc3);
        wait_irq();
        chk("far end byte", {24'h000000, rx_byte}, 32'h000000c3);
        chk("far end valid", {31'h00000000, rx_seen}, 32'h00000001);
        stop_bus();
        $display("test master write done");
        wr(`ISM_OFS_DATA, 8'h55);
        wr(`ISM_OFS_CTRL_TWO, 8'h0b);
        wait_irq();
        rd(`ISM_OFS_STATUS, v);
        chk("status read address", v, 32'h000000a0);
        rd(`ISM_OFS_DATA, v);
        wr(`ISM_OFS_DATA, 8'h00);
        tx_byte <= 8'h3c;
        wait_irq();
        rd(`ISM_OFS_DATA, v);
        chk("first read byte", v, 32'h00000096);
        rd(`ISM_OFS_STATUS, v);
        chk("ack from device", v, 32'h000000a0);
        wr(`ISM_OFS_CTRL_ONE, 8'h00);
        wr(`ISM_OFS_DATA, 8'h00);
        wait_irq();
        rd(`ISM_OFS_DATA, v);
        chk("last read byte", v, 32'h0000003c);
        wr(`ISM_OFS_CTRL_ONE, 8'h01);
        wr(`ISM_OFS_DATA, 8'h00);
        wait_irq();
        rd(`ISM_OFS_STATUS, v);
        chk("single high bit", v, 32'h000000a1);
        chk("far end nack", {31'h00000000, nack_seen}, 32'h00000001);
        chk("far end loads", taken, 32'h00000002);
        stop_bus();
        $display("test master read done");
        final_report();
    end
endmodule // tb_i2c_master_rx_slave_service

`default_nettype wire
